// ---- rtl/fmc_regs.vh ----
// Register map, field positions, mode codes and timing counts of the
// fail-safe mode controller. Definitions only; include by bare name.
`ifndef FMC_REGS_VH
`define FMC_REGS_VH

// Byte offsets on the register bus
`define FMC_OFF_CFG0         12'h000
`define FMC_OFF_CFG1         12'h004
`define FMC_OFF_CFG2         12'h008
`define FMC_OFF_TRIM         12'h00C
`define FMC_OFF_STAT         12'h010

// CFG0: thresholds and sense ranges
`define FMC_THR1_LSB         0
`define FMC_RNG1_LSB         8
`define FMC_THR2_LSB         16
`define FMC_RNG2_LSB         24
// CFG1: off-time codes
`define FMC_TOFF1_LSB        0
`define FMC_TOFF2_LSB        8
// CFG2: enables, mode select, overcurrent, thermal auto-recover
`define FMC_EN2_BIT          0
`define FMC_EN1_BIT          1
`define FMC_MODE_LSB         2
`define FMC_OC_LSB           5
`define FMC_TSD1_BIT         8
`define FMC_TSD2_BIT         9
// TRIM: sense trim values (read only)
`define FMC_TRIM1_LSB        0
`define FMC_TRIM2_LSB        8
// STAT: flags and state (read clears both flags in normal, fail-safe or stand-alone state unless the latched mode locks the bus)
`define FMC_ST_FS_BIT        0
`define FMC_ST_SERR_BIT      1
`define FMC_ST_HOLD_BIT      2
`define FMC_ST_STATE_LSB     4
`define FMC_ST_SHADOW_LSB    8

// Reset value of all control registers
`define FMC_RST_CFG          32'h0000_0000

// Protection mode select codes
`define FMC_MD_OFF           3'h0
`define FMC_MD_OTP           3'h1
`define FMC_MD_SA_LOCK       3'h6

// Bus responses
`define FMC_RESP_OKAY        2'h0
`define FMC_RESP_SLVERR      2'h2

// Init delay
`define FMC_INIT_DELAY_US    150
`define FMC_CLK_MHZ          100
`define FMC_INIT_DELAY_CYC   (`FMC_INIT_DELAY_US * `FMC_CLK_MHZ)

`endif

// ---- rtl/fmc_sync.v ----
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherency.
`timescale 1ns/100ps
module fmc_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  // Pins in, synchronised levels out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else if (ce) begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // fmc_sync

// ---- rtl/fmc_delay.v ----
// One-shot delay: done pulses CYCLES enabled cycles after start.
// Assumes start is a single-cycle pulse from the same clock; a new start restarts.
`timescale 1ns/100ps
module fmc_delay #(
  parameter CYCLES = 15000
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  input  wire ce,
  // Control
  input  wire start,
  output reg  done
);
  localparam         W    = $clog2(CYCLES + 1);
  localparam [W-1:0] LOAD = CYCLES - 1;

  reg [W-1:0] cnt_reg;
  reg         run_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= LOAD;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg == {W{1'b0}}) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule // fmc_delay

// ---- rtl/fmc_mode_ctrl.v ----
// Functional-mode controller of a dual-channel LED driver: reset, init,
// normal, fail-safe and stand-alone states, register file on AXI4-Lite.
// Assumes the AXI4-Lite master stands in for the serial port, the serial
// frame checker reports bad frames on serial_frame_error (same clock),
// and the one-time-memory image is stable static inputs.
`timescale 1ns/100ps
`include "fmc_regs.vh"
module fmc_mode_ctrl #(
  parameter INIT_CYCLES = `FMC_INIT_DELAY_CYC
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // Device pins
  input  wire        external_reset_pin_n,
  input  wire [1:0]  channel_control_pin,
  // One-time memory image
  input  wire        otp_programmed,
  input  wire        otp_lock,
  input  wire [31:0] otp_cfg0,
  input  wire [31:0] otp_cfg1,
  input  wire [31:0] otp_cfg2,
  input  wire [6:0]  otp_range1,
  input  wire [6:0]  otp_range2,
  // Serial frame checker
  input  wire        serial_frame_error,
  // AXI4-Lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Status to the regulators
  output reg  [1:0]  buck_enable_out,
  output reg         pins_ignored_out,
  output reg         device_in_reset_out,
  output reg         failsafe_active_out,
  output reg         standalone_active_out
);
  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_INIT  = 3'h1;
  localparam [2:0] ST_NORM  = 3'h2;
  localparam [2:0] ST_FS    = 3'h3;
  localparam [2:0] ST_SA    = 3'h4;

  localparam [1:0] LD_NONE   = 2'h0;
  localparam [1:0] LD_ZERO   = 2'h1;
  localparam [1:0] LD_KEEPMD = 2'h2;
  localparam [1:0] LD_OTP    = 2'h3;

  // Modes in which a pin falling edge enters fail-safe
  function fs_by_pin;
    input [2:0] m;
    begin
      fs_by_pin = (m >= 3'h2) && (m <= 3'h5);
    end
  endfunction

  // Latched modes that lock out register writes and read-clearing
  function bus_locked;
    input [2:0] m;
    begin
      bus_locked = (m != `FMC_MD_OFF) && !m[0];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Pin synchronisation and edges
  wire [2:0] pins_s;
  wire       init_done;
  reg        pin_prev_reg;

  fmc_sync #(
    .W       (3),
    .RST_VAL (3'b100)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({external_reset_pin_n, channel_control_pin}),
    .q   (pins_s)
  );

  wire pin_fall = pin_prev_reg & ~pins_s[2];
  wire pin_rise = ~pin_prev_reg & pins_s[2];

  // Control state
  reg [2:0]  state_reg, state_next;
  reg [2:0]  shadow_reg, shadow_next;
  reg        hold_reg, hold_next;
  reg        fs_flag_reg;
  reg        serr_flag_reg;
  reg [31:0] cfg0_reg, cfg1_reg, cfg2_reg, trim_reg;
  reg [31:0] otp0_reg, otp1_reg, otp2_reg, otp_trim_reg;
  reg        otp_ok_reg;
  reg [1:0]  load_kind;
  reg        init_start;
  reg        fs_set;

  // Bus slave state
  reg [11:0] aw_addr_reg;
  reg        aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_have_reg;
  reg [31:0] rd_data;
  reg        rd_hit;

  wire [2:0] mode_reg   = cfg2_reg[`FMC_MODE_LSB +: 3];
  wire [2:0] otp_md     = otp_ok_reg ? otp2_reg[`FMC_MODE_LSB +: 3] : `FMC_MD_OFF;
  wire       active     = (state_reg == ST_NORM) | (state_reg == ST_FS) | (state_reg == ST_SA);
  wire       bus_open   = active & ~bus_locked(shadow_reg);
  wire       do_write   = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire       wr_hit     = (aw_addr_reg == `FMC_OFF_CFG0) | (aw_addr_reg == `FMC_OFF_CFG1)
                        | (aw_addr_reg == `FMC_OFF_CFG2);
  wire       wr_apply   = do_write & wr_hit & bus_open;
  wire [31:0] cfg2_wr   = merge(cfg2_reg, w_data_reg, w_strb_reg);
  wire [2:0] wr_md      = cfg2_wr[`FMC_MODE_LSB +: 3];
  wire       exit_wr    = wr_apply & (aw_addr_reg == `FMC_OFF_CFG2)
                        & (wr_md == `FMC_MD_OFF || wr_md == `FMC_MD_OTP)
                        & shadow_reg[0] & (shadow_reg != `FMC_MD_OTP);
  wire       ar_take    = s_axi_arready & s_axi_arvalid;
  wire       stat_clr   = ar_take & (s_axi_araddr == `FMC_OFF_STAT) & bus_open;
  wire       op_done    = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);

  fmc_delay #(
    .CYCLES (INIT_CYCLES)
  ) u_init (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (init_start),
    .done  (init_done)
  );

  // Mode sequencing
  always @* begin
    state_next  = state_reg;
    shadow_next = shadow_reg;
    hold_next   = hold_reg & ~op_done;
    load_kind   = LD_NONE;
    init_start  = 1'b0;
    fs_set      = 1'b0;
    case (state_reg)
      ST_RESET: begin
        // Held here while the pin is low
        if (pins_s[2]) begin
          state_next = ST_INIT;
          init_start = 1'b1;
        end
      end
      ST_INIT: begin
        if (init_done) begin
          state_next = ST_NORM;
          case (otp_md)
            3'h0: load_kind = LD_ZERO;
            3'h1: load_kind = LD_OTP;
            3'h2, 3'h3: load_kind = LD_KEEPMD;
            3'h4, 3'h5: begin
              load_kind = LD_OTP;
              hold_next = 1'b1;
            end
            default: begin
              load_kind   = LD_OTP;
              state_next  = ST_SA;
              shadow_next = otp_md;
            end
          endcase
        end
      end
      ST_NORM: begin
        if (pin_fall) begin
          if (fs_by_pin(mode_reg)) begin
            // Without a locked memory image the edge is ignored
            if (otp_ok_reg) begin
              state_next  = ST_FS;
              shadow_next = mode_reg;
              load_kind   = LD_OTP;
              fs_set      = 1'b1;
              hold_next   = 1'b0;
            end
          end else begin
            state_next  = ST_RESET;
            shadow_next = `FMC_MD_OFF;
          end
        end
      end
      ST_FS: begin
        // Falling edges are ignored here
        if (pin_rise | exit_wr) begin
          state_next  = ST_NORM;
          shadow_next = `FMC_MD_OFF;
        end
      end
      ST_SA: begin
        if (pin_fall) begin
          state_next  = ST_RESET;
          shadow_next = `FMC_MD_OFF;
        end else if (exit_wr) begin
          state_next  = ST_NORM;
          shadow_next = `FMC_MD_OFF;
        end
      end
      default: begin
        state_next  = ST_RESET;
        shadow_next = `FMC_MD_OFF;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_RESET;
      shadow_reg    <= `FMC_MD_OFF;
      hold_reg      <= 1'b0;
      pin_prev_reg  <= 1'b1;
      fs_flag_reg   <= 1'b0;
      serr_flag_reg <= 1'b0;
      otp0_reg      <= `FMC_RST_CFG;
      otp1_reg      <= `FMC_RST_CFG;
      otp2_reg      <= `FMC_RST_CFG;
      otp_trim_reg  <= `FMC_RST_CFG;
      otp_ok_reg    <= 1'b0;
    end else if (ce) begin
      state_reg    <= state_next;
      shadow_reg   <= shadow_next;
      hold_reg     <= hold_next;
      pin_prev_reg <= pins_s[2];
      // Set wins over a read-clear in the same cycle
      if (fs_set)
        fs_flag_reg <= 1'b1;
      else if (stat_clr)
        fs_flag_reg <= 1'b0;
      if (serial_frame_error)
        serr_flag_reg <= 1'b1;
      else if (stat_clr)
        serr_flag_reg <= 1'b0;
      // Memory refresh at the start of init
      if (init_start) begin
        otp0_reg     <= otp_cfg0;
        otp1_reg     <= otp_cfg1;
        otp2_reg     <= otp_cfg2;
        otp_trim_reg <= {17'h0_0000, otp_range2, 1'b0, otp_range1};
        otp_ok_reg   <= otp_programmed & otp_lock;
      end
    end
  end

  // Control registers: a load from the sequencer beats a bus write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg0_reg <= `FMC_RST_CFG;
      cfg1_reg <= `FMC_RST_CFG;
      cfg2_reg <= `FMC_RST_CFG;
      trim_reg <= `FMC_RST_CFG;
    end else if (ce) begin
      case (load_kind)
        LD_ZERO: begin
          cfg0_reg <= `FMC_RST_CFG;
          cfg1_reg <= `FMC_RST_CFG;
          cfg2_reg <= `FMC_RST_CFG;
          trim_reg <= `FMC_RST_CFG;
        end
        LD_KEEPMD: begin
          cfg0_reg <= `FMC_RST_CFG;
          cfg1_reg <= `FMC_RST_CFG;
          cfg2_reg <= {27'h000_0000, otp_md, 2'h0};
          trim_reg <= `FMC_RST_CFG;
        end
        LD_OTP: begin
          cfg0_reg <= otp0_reg;
          cfg1_reg <= otp1_reg;
          cfg2_reg <= otp2_reg;
          trim_reg <= otp_trim_reg;
        end
        default: begin
          if (wr_apply) begin
            case (aw_addr_reg)
              `FMC_OFF_CFG0: cfg0_reg <= merge(cfg0_reg, w_data_reg, w_strb_reg);
              `FMC_OFF_CFG1: cfg1_reg <= merge(cfg1_reg, w_data_reg, w_strb_reg);
              default:       cfg2_reg <= cfg2_wr;
            endcase
          end
        end
      endcase
    end
  end

  // Read decode
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `FMC_OFF_CFG0: rd_data = cfg0_reg;
      `FMC_OFF_CFG1: rd_data = cfg1_reg;
      `FMC_OFF_CFG2: rd_data = cfg2_reg;
      `FMC_OFF_TRIM: rd_data = trim_reg;
      `FMC_OFF_STAT: begin
        rd_data[`FMC_ST_FS_BIT]            = fs_flag_reg;
        rd_data[`FMC_ST_SERR_BIT]          = serr_flag_reg;
        rd_data[`FMC_ST_HOLD_BIT]          = hold_reg;
        rd_data[`FMC_ST_STATE_LSB +: 3]    = state_reg;
        rd_data[`FMC_ST_SHADOW_LSB +: 3]   = shadow_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite slave; address and data taken in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FMC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `FMC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr_reg   <= 12'h000;
      aw_have_reg   <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      w_have_reg    <= 1'b0;
    end else if (ce) begin
      if (s_axi_awready & s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= {s_axi_awaddr[11:2], 2'b00};
        aw_have_reg   <= 1'b1;
      end
      if (s_axi_wready & s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
      end
      // Blocked writes still answer OKAY; only writes outside CFG0-CFG2 fail
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_hit ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Channel enables and mode outputs
  wire [1:0] en_bits = {cfg2_reg[`FMC_EN2_BIT], cfg2_reg[`FMC_EN1_BIT]};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      buck_enable_out       <= 2'b00;
      pins_ignored_out      <= 1'b0;
      device_in_reset_out   <= 1'b1;
      failsafe_active_out   <= 1'b0;
      standalone_active_out <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_NORM: buck_enable_out <= en_bits & pins_s[1:0] & {2{~hold_reg}};
        ST_FS, ST_SA: buck_enable_out <= en_bits;
        default: buck_enable_out <= 2'b00;
      endcase
      pins_ignored_out      <= (state_reg == ST_FS) | (state_reg == ST_SA);
      device_in_reset_out   <= (state_reg == ST_RESET) | (state_reg == ST_INIT);
      failsafe_active_out   <= (state_reg == ST_FS);
      standalone_active_out <= (state_reg == ST_SA);
    end
  end
endmodule // fmc_mode_ctrl

// ---- tb/fmc_mcu_model.sv ----
// Microcontroller side of the mode controller: reset pin, channel pins, bad frames.
// Assumes one clock; every change lands just after a rising edge.
`timescale 1ns/100ps
module fmc_mcu_model (
  // Clock
  input  wire       clk,
  // Pins toward the device
  output reg        external_reset_pin_n,
  output reg  [1:0] channel_control_pin,
  output reg        serial_frame_error
);
  initial begin
    external_reset_pin_n = 1'b1;
    channel_control_pin  = 2'b00;
    serial_frame_error   = 1'b0;
  end
  // Held five cycles: synchroniser, state and output flops all lag the pin
  task set_pin(input v);
    begin
      @(posedge clk);
      external_reset_pin_n <= v;
      repeat (5) @(posedge clk);
    end
  endtask
  task set_ctrl(input [1:0] v);
    begin
      @(posedge clk);
      channel_control_pin <= v;
      repeat (4) @(posedge clk);
    end
  endtask
  task frame_err;
    begin
      @(posedge clk);
      serial_frame_error <= 1'b1;
      @(posedge clk);
      serial_frame_error <= 1'b0;
    end
  endtask
endmodule // fmc_mcu_model

// ---- tb/fmc_mode_ctrl_monitor.sv ----
// Concurrent checks on the mode controller's pins and bus handshakes.
// Bound to fmc_mode_ctrl; one clock, asynchronous reset rst.
`timescale 1ns/100ps
module fmc_mode_ctrl_monitor #(
  parameter INIT_CYCLES = 15000
) (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Pins
  input wire       external_reset_pin_n,
  input wire [1:0] channel_control_pin,
  // Bus handshakes
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  // State outputs
  input wire [1:0] buck_enable_out,
  input wire       pins_ignored_out,
  input wire       device_in_reset_out,
  input wire       failsafe_active_out,
  input wire       standalone_active_out
);
  reg [31:0] in_rst_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst)
      in_rst_cnt <= 32'h0;
    else if (device_in_reset_out)
      in_rst_cnt <= in_rst_cnt + 32'h1;
    else
      in_rst_cnt <= 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sa_fall;
    standalone_active_out ##0 $fell(external_reset_pin_n);
  endsequence
  sequence s_fs_pin_low;
    failsafe_active_out && !external_reset_pin_n;
  endsequence
  AST_POR_RESET: assert property ($past(rst) |-> device_in_reset_out)
    else $error("not in reset after power-on reset");
  AST_INIT_DELAY: assert property ($fell(device_in_reset_out) |-> in_rst_cnt >= INIT_CYCLES)
    else $error("init left too early");
  AST_PIN_IGNORED: assert property ((failsafe_active_out || standalone_active_out)
    |-> pins_ignored_out)
    else $error("pins not ignored in fail-safe or stand-alone");
  AST_SA_PIN_RESET: assert property (s_sa_fall |-> ##[1:6] device_in_reset_out)
    else $error("stand-alone pin fall did not reset");
  AST_FS_PIN_BLOCK: assert property (s_fs_pin_low |=> !device_in_reset_out [*3])
    else $error("pin reset not blocked in fail-safe");
  AST_CTRL_GATES: assert property (buck_enable_out[0] && !pins_ignored_out
    && $past(!pins_ignored_out, 4) |-> $past(channel_control_pin[0], 2)
    || $past(channel_control_pin[0], 3) || $past(channel_control_pin[0], 4))
    else $error("channel enabled without its control pin");
  AST_EXIT_NORMAL: assert property ($fell(failsafe_active_out) && !device_in_reset_out
    |-> !pins_ignored_out)
    else $error("pins still ignored after fail-safe exit");
  AST_B_AFTER_AW: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule // fmc_mode_ctrl_monitor

// ---- tb/fmc_mode_ctrl_bench.sv ----
// Self-checking bench of the mode controller: bus master, memory image, pin model.
// Assumes INIT_CYCLES shortened to 20; reads are checked by a watcher process.
`timescale 1ns/100ps
`include "fmc_regs.vh"
module fmc_mode_ctrl_bench;
  localparam INIT_CYCLES = 20;
  localparam [31:0] M0 = 32'h03FF03FF;
  reg         clk, rst, ce, otp_programmed, otp_lock;
  reg  [31:0] otp_cfg0, otp_cfg1, otp_cfg2, s_axi_wdata;
  reg  [6:0]  otp_range1, otp_range2;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        external_reset_pin_n, serial_frame_error;
  wire [1:0]  channel_control_pin, s_axi_bresp, s_axi_rresp, buck_enable_out;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [31:0] s_axi_rdata;
  wire        pins_ignored_out, device_in_reset_out, failsafe_active_out, standalone_active_out;
  logic [31:0] exp_q[$], msk_q[$];
  logic [1:0]  rsp_q[$];
  integer     seed, n_errors, cmp_count, cyc;

  fmc_mode_ctrl #(.INIT_CYCLES(INIT_CYCLES)) dut (.*);
  fmc_mcu_model mcu (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk_val(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("FAIL %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task give_verdict;
    begin
      if (exp_q.size() != 0)
        n_errors = n_errors + 1;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task axi_wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Only the bench watchdog ends a wait for the answer
      while (!s_axi_bvalid) begin
        @(posedge clk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk_val("bresp", er, s_axi_bresp);
    end
  endtask
  task axi_rd(input [11:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
    begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      rsp_q.push_back(er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!s_axi_rvalid) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
    end
  endtask
  // Results are matched in issue order; one read outstanding keeps it simple
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      chk_val("rdata", exp_q.pop_front(), s_axi_rdata & msk_q.pop_front());
      chk_val("rresp", rsp_q.pop_front(), s_axi_rresp);
    end
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task por(input [2:0] md, input [1:0] v);
    integer n;
    begin
      mcu.set_pin(1'b1);
      {otp_programmed, otp_lock} <= v;
      otp_cfg0 <= $random(seed);
      otp_cfg1 <= $random(seed);
      otp_range1 <= $random(seed);
      otp_range2 <= $random(seed);
      otp_cfg2 <= ($random(seed) & 32'h360) | ({29'h0, md} << 2) | 32'h3;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (device_in_reset_out && n < INIT_CYCLES + 60);
      repeat (2) @(posedge clk);
    end
  endtask

  initial begin
    seed = 86;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    {rst, ce} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    // Programmed but not locked: mode 011 image must be treated as mode 000
    por(3'h3, 2'b10);
    axi_rd(`FMC_OFF_CFG2, 32'h0, 32'h3FF, `FMC_RESP_OKAY);
    axi_rd(12'h020, 32'h0, 32'hFFFFFFFF, `FMC_RESP_SLVERR);
    axi_wr(`FMC_OFF_TRIM, 32'h0, 4'hF, `FMC_RESP_SLVERR);
    axi_wr(`FMC_OFF_CFG2, 32'h3, 4'hF, `FMC_RESP_OKAY);
    mcu.set_ctrl(2'b10);
    chk_val("buck_en", 2'b10, buck_enable_out);
    mcu.set_pin(1'b0);
    chk_val("in_reset", 1'b1, device_in_reset_out);
    $display("test 1 done");
    por(3'h3, 2'b11);
    axi_rd(`FMC_OFF_CFG2, 32'h00C, 32'h3FF, `FMC_RESP_OKAY);
    mcu.set_ctrl(2'b00);
    mcu.set_pin(1'b0);
    repeat (2) @(posedge clk);
    chk_val("fs_active", 1'b1, failsafe_active_out);
    chk_val("buck_en", 2'b11, buck_enable_out);
    axi_rd(`FMC_OFF_CFG0, otp_cfg0, M0, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_CFG1, otp_cfg1, 32'h1F1F, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_TRIM, {17'h0, otp_range2, 1'b0, otp_range1}, 32'h7F7F, `FMC_RESP_OKAY);
    mcu.frame_err;
    axi_rd(`FMC_OFF_STAT, 32'h333, 32'h773, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_STAT, 32'h0, 32'h3, `FMC_RESP_OKAY);
    axi_wr(`FMC_OFF_CFG2, 32'h3, 4'hF, `FMC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk_val("fs_active", 1'b0, failsafe_active_out);
    chk_val("buck_en", 2'b00, buck_enable_out);
    axi_rd(`FMC_OFF_STAT, 32'h0, 32'h700, `FMC_RESP_OKAY);
    axi_wr(`FMC_OFF_CFG1, 32'h1F1F, 4'h2, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_CFG1, {16'h0, 8'h1F, otp_cfg1[7:0]}, 32'h1F1F, `FMC_RESP_OKAY);
    $display("test 2 done");
    por(3'h2, 2'b11);
    mcu.set_pin(1'b0);
    axi_wr(`FMC_OFF_CFG0, $random(seed), 4'hF, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_CFG0, otp_cfg0, M0, `FMC_RESP_OKAY);
    mcu.frame_err;
    axi_rd(`FMC_OFF_STAT, 32'h2, 32'h2, `FMC_RESP_OKAY);
    axi_rd(`FMC_OFF_STAT, 32'h2, 32'h2, `FMC_RESP_OKAY);
    mcu.set_pin(1'b1);
    repeat (2) @(posedge clk);
    chk_val("fs_active", 1'b0, failsafe_active_out);
    $display("test 3 done");
    por(3'h5, 2'b11);
    mcu.set_ctrl(2'b11);
    chk_val("buck_en", 2'b00, buck_enable_out);
    axi_rd(`FMC_OFF_CFG0, otp_cfg0, M0, `FMC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk_val("buck_en", 2'b11, buck_enable_out);
    mcu.set_pin(1'b0);
    repeat (2) @(posedge clk);
    chk_val("fs_active", 1'b1, failsafe_active_out);
    axi_wr(`FMC_OFF_CFG2, 32'h7, 4'h1, `FMC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk_val("fs_active", 1'b0, failsafe_active_out);
    $display("test 4 done");
    por(3'h6, 2'b11);
    mcu.set_ctrl(2'b00);
    chk_val("sa_active", 1'b1, standalone_active_out);
    chk_val("buck_en", 2'b11, buck_enable_out);
    mcu.set_pin(1'b0);
    chk_val("in_reset", 1'b1, device_in_reset_out);
    $display("test 5 done");
    por(3'h1, 2'b11);
    axi_rd(`FMC_OFF_CFG0, otp_cfg0, M0, `FMC_RESP_OKAY);
    mcu.set_pin(1'b0);
    chk_val("fs_active", 1'b0, failsafe_active_out);
    chk_val("in_reset", 1'b1, device_in_reset_out);
    $display("test 6 done");
    give_verdict;
  end
endmodule // fmc_mode_ctrl_bench

bind fmc_mode_ctrl fmc_mode_ctrl_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_mon (.*);
